/* File: verilog/pfc_map.svh */
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define PFC_ADDR_WIDTH 5
`define PFC_OFS_MODCFG 5'h00
`define PFC_OFS_PAGE 5'h04
`define PFC_OFS_PORT_B_ALT_SELECT 5'h08
`define PFC_OFS_PORT_C_ALT_SELECT 5'h0C
`define PFC_OFS_PORT_D_ALT_SELECT 5'h10
`define PFC_OFS_PORT_E_ALT_SELECT 5'h14
`define PFC_OFS_STATUS 5'h18
// ---------------------------------------------------------------
// configuration fields
// ---------------------------------------------------------------
`define PFC_BIT_SHADOW_OFF 0
`define PFC_BIT_SHEN 1
`define PFC_BIT_WIDE 2
`define PFC_BIT_A15 3
`define PFC_BIT_EXIO 4
`define PFC_BIT_CLKO 5
`define PFC_BIT_TEST 6
`define PFC_MODCFG_WMASK 8'h3F
`define PFC_MODCFG_RST 8'h00
`define PFC_PAGE_RST 3'h0
`define PFC_ALT_RST 8'h00
`define PFC_PB5_BIT 5
`define PFC_PB6_BIT 6
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
// edges after power-up release before the straps are trusted
`define PFC_STRAP_WAIT 2'h2
`endif

/* File: verilog/pfc_pkg.sv */
`default_nettype none
package pfc_pkg;
   // operating environment, one-hot
   typedef enum logic [2:0] {
      PFC_ENV_IRE = 3'b001,
      PFC_ENV_IRD = 3'b010,
      PFC_ENV_DEV = 3'b100
   } pfc_env_e;
   typedef logic [7:0] pfc_byte_t;
endpackage
`default_nettype wire

/* File: verilog/pfc_sync2.sv */
`default_nettype none
module pfc_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1_reg;

   if (WIDTH < 1) begin : g_bad_width
      $error("pfc_sync2: WIDTH must be positive");
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1_reg <= '0;
         dout <= '0;
      end else begin
         stage1_reg <= din;
         dout <= stage1_reg;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/pfc_pad_mux.sv */
`default_nettype none
module pfc_pad_mux #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // selection
   input wire logic [WIDTH-1:0] altSel,
   // port and alternate drivers
   input wire logic [WIDTH-1:0] gpOut,
   input wire logic [WIDTH-1:0] gpOe,
   input wire logic [WIDTH-1:0] altOut,
   input wire logic [WIDTH-1:0] altOe,
   // pads
   output logic [WIDTH-1:0] padOut,
   output logic [WIDTH-1:0] padOe
);
   logic [WIDTH-1:0] outNext;
   logic [WIDTH-1:0] oeNext;

   if (WIDTH < 1) begin : g_bad_width
      $error("pfc_pad_mux: WIDTH must be positive");
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign outNext[i] = altSel[i] ? altOut[i] : gpOut[i];
         assign oeNext[i] = altSel[i] ? altOe[i] : gpOe[i];
      end
   endgenerate

   // registered so pads never glitch while a select changes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         padOut <= '0;
         padOe <= '0;
      end else begin
         padOut <= outNext;
         padOe <= oeNext;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/pfc_top.sv */
// How it works
// - port B bit5 always output high, never alternate
// - port B bit6 always output, alternate enabled
// - reset clears configuration register bits
// - configuration writes only in active mode
// - dev environments force F G alternates
// - shadow-off removes shadow, enables external memory
// - host access needs shared-enable and shadow-off
// - width bit picks 8 or 16 bit memory
// - wide memory uses port F, G3 and G4
// - address15 enable puts A15 on G1
// - shared BIOS detect sets address15 enable
// - expansion enable drives select on G0
// - clock enable drives clock on G2
// - bit6 read-only test flag
// - page field gives upper core addresses
// - allowed host access takes upper address from host
// - alt registers select B C D E functions
// - port H alternate only in development
// - environment from two straps at power-up
`include "pfc_map.svh"
`default_nettype none
module pfc_top #(
   // alternate-select registers, one per port B..E
   parameter int ALT_PORTS = 4,
   // page field width, upper shared-memory address bits
   parameter int PAGE_BITS = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic porResetn,
   // classic wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [`PFC_ADDR_WIDTH-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   // system state and straps
   input wire logic activeMode,
   input wire logic testHook,
   input wire logic sharedBiosDetect,
   input wire logic environmentStrapLo,
   input wire logic environmentStrapHi,
   // shared memory access
   input wire logic hostAccess,
   input wire logic [2:0] hostAddrHi,
   output logic [2:0] memAddrHi,
   output logic hostAccessAllowed,
   output logic shadowActive,
   output logic externalMemEnable,
   output logic externalWide,
   output pfc_pkg::pfc_env_e envState,
   // port B..E pads
   input wire logic [31:0] gpOutBE,
   input wire logic [31:0] gpOeBE,
   input wire logic [31:0] altOutBE,
   input wire logic [31:0] altOeBE,
   output logic [31:0] padOutBE,
   output logic [31:0] padOeBE,
   // port F, G, H pads
   input wire logic [18:0] gpOutFGH,
   input wire logic [18:0] gpOeFGH,
   input wire logic [18:0] altOutFGH,
   input wire logic [18:0] altOeFGH,
   output logic [18:0] padOutFGH,
   output logic [18:0] padOeFGH
);
   import pfc_pkg::*;

   // pin layout below is fixed to four ports and a three-bit page
   if (ALT_PORTS != 4 || PAGE_BITS != 3) begin : g_bad_param
      $error("pfc_top: only ALT_PORTS 4 and PAGE_BITS 3 supported");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pfc_byte_t modCfg_reg;
   logic [PAGE_BITS-1:0] page_reg;
   pfc_byte_t alt_reg [0:ALT_PORTS-1];
   pfc_env_e env_reg;
   logic strapTaken_reg;
   logic [1:0] strapWait_reg;
   logic a15Seen_reg;
   logic [1:0] strapSync;
   logic testSync;
   logic activeSync;

   pfc_sync2 #(.WIDTH(4)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .din({environmentStrapHi, environmentStrapLo, testHook, activeMode}),
      .dout({strapSync, testSync, activeSync})
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire busReq = wbCyc && wbStb && !wbAck;
   wire wrByte0 = busReq && wbWe && wbSel[0];
   wire selCfg = wbAdr == `PFC_OFS_MODCFG;
   wire selPage = wbAdr == `PFC_OFS_PAGE;
   wire selPb = wbAdr == `PFC_OFS_PORT_B_ALT_SELECT;
   wire selPc = wbAdr == `PFC_OFS_PORT_C_ALT_SELECT;
   wire selPd = wbAdr == `PFC_OFS_PORT_D_ALT_SELECT;
   wire selPe = wbAdr == `PFC_OFS_PORT_E_ALT_SELECT;
   wire selSts = wbAdr == `PFC_OFS_STATUS;
   wire [3:0] selAlt = {selPe, selPd, selPc, selPb};
   wire cfgWrite = wrByte0 && selCfg && activeSync;
   wire [7:0] cfgWrData = wbDatI[7:0] & `PFC_MODCFG_WMASK;
   wire [7:0] cfgRead = {1'b0, testSync, modCfg_reg[5:0]};
   wire [7:0] envRead = {5'h00, env_reg};
   wire [7:0] rdByte =
      selCfg ? cfgRead :
      selPage ? {5'h00, page_reg} :
      selPb ? alt_reg[0] :
      selPc ? alt_reg[1] :
      selPd ? alt_reg[2] :
      selPe ? alt_reg[3] :
      selSts ? envRead : 8'h00;

   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   wire shadowOff = modCfg_reg[`PFC_BIT_SHADOW_OFF];
   wire sharedEn = modCfg_reg[`PFC_BIT_SHEN];
   wire wideSel = modCfg_reg[`PFC_BIT_WIDE];
   wire a15Sel = modCfg_reg[`PFC_BIT_A15];
   wire exioSel = modCfg_reg[`PFC_BIT_EXIO];
   wire clkoSel = modCfg_reg[`PFC_BIT_CLKO];
   wire isIre = env_reg == PFC_ENV_IRE;
   wire isDev = env_reg == PFC_ENV_DEV;
   wire hostOk = sharedEn && shadowOff;
   // a15 set once on detect rising; firmware may clear after
   wire a15Set = sharedBiosDetect && !a15Seen_reg;
   wire [7:0] cfgNext =
      a15Set ? ((cfgWrite ? cfgWrData : modCfg_reg) | 8'h08) :
      (cfgWrite ? cfgWrData : modCfg_reg);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         modCfg_reg <= `PFC_MODCFG_RST;
         page_reg <= `PFC_PAGE_RST;
         a15Seen_reg <= 1'b0;
         wbAck <= 1'b0;
         wbDatO <= 32'h0000_0000;
      end else begin
         modCfg_reg <= cfgNext;
         a15Seen_reg <= sharedBiosDetect;
         if (wrByte0 && selPage) begin
            page_reg <= wbDatI[PAGE_BITS-1:0];
         end
         wbAck <= busReq;
         wbDatO <= {24'h000000, rdByte};
      end
   end

   genvar p;
   generate
      for (p = 0; p < ALT_PORTS; p++) begin : g_alt
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               alt_reg[p] <= `PFC_ALT_RST;
            end else if (wrByte0 && selAlt[p]) begin
               alt_reg[p] <= wbDatI[7:0];
            end
         end
      end
   endgenerate

   // strap capture after power-up release only; warm reset keeps it
   // the synchroniser is cleared by reset too, so capture waits until
   // both of its stages hold the pin level, else every start reads 00
   always_ff @(posedge clk or negedge porResetn) begin
      if (!porResetn) begin
         env_reg <= PFC_ENV_IRE;
         strapTaken_reg <= 1'b0;
         strapWait_reg <= 2'h0;
      end else if (!strapTaken_reg) begin
         if (strapWait_reg == `PFC_STRAP_WAIT) begin
            strapTaken_reg <= 1'b1;
            case (strapSync)
               2'b00: env_reg <= PFC_ENV_IRE;
               2'b10: env_reg <= PFC_ENV_IRD;
               2'b01: env_reg <= PFC_ENV_DEV;
               default: env_reg <= PFC_ENV_DEV;
            endcase
         end else begin
            strapWait_reg <= strapWait_reg + 2'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // memory control outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         memAddrHi <= 3'h0;
         hostAccessAllowed <= 1'b0;
         shadowActive <= 1'b1;
         externalMemEnable <= 1'b0;
         externalWide <= 1'b0;
         envState <= PFC_ENV_IRE;
      end else begin
         // host address wins during host cycles while host access is allowed
         memAddrHi <= (hostAccess && hostOk) ? hostAddrHi : page_reg;
         hostAccessAllowed <= hostOk;
         shadowActive <= !shadowOff;
         externalMemEnable <= shadowOff;
         externalWide <= wideSel;
         envState <= env_reg;
      end
   end

   // ---------------------------------------------------------------
   // port B..E selects
   // ---------------------------------------------------------------
   wire [31:0] altSelBE;
   wire [31:0] gpOutBEm;
   wire [31:0] gpOeBEm;
   // B5 forced port, B6 forced alternate output
   assign altSelBE = {alt_reg[3], alt_reg[2], alt_reg[1],
      alt_reg[0][7], 1'b1, 1'b0, alt_reg[0][4:0]};
   // gate-a20 forced high as an output; firmware cannot drive it low
   assign gpOutBEm = gpOutBE | (32'h1 << `PFC_PB5_BIT);
   assign gpOeBEm = gpOeBE | (32'h1 << `PFC_PB5_BIT);

   wire [31:0] altOeBEm = altOeBE | (32'h1 << `PFC_PB6_BIT);

   pfc_pad_mux #(.WIDTH(32)) u_mux_be (
      .clk(clk),
      .resetn(resetn),
      .altSel(altSelBE),
      .gpOut(gpOutBEm),
      .gpOe(gpOeBEm),
      .altOut(altOutBE),
      .altOe(altOeBEm),
      .padOut(padOutBE),
      .padOe(padOeBE)
   );

   // ---------------------------------------------------------------
   // port F, G, H selects
   // bits 7:0 = F, 12:8 = G0..G4, 18:13 = H0..H5
   // ---------------------------------------------------------------
   wire forceDevUse = !isIre;
   wire fSel = forceDevUse || wideSel;
   wire g0Sel = forceDevUse || exioSel;
   wire g1Sel = forceDevUse || a15Sel;
   wire g2Sel = forceDevUse || clkoSel;
   wire [18:0] altSelFGH = {{6{isDev}}, fSel, fSel, g2Sel, g1Sel, g0Sel,
      {8{fSel}}};
   // clock output follows clk through the pad register at half rate
   logic clkDiv_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clkDiv_reg <= 1'b0;
      end else begin
         clkDiv_reg <= !clkDiv_reg;
      end
   end
   wire [18:0] altOutFGHm = {altOutFGH[18:11], clkDiv_reg,
      altOutFGH[9:0]};
   wire [18:0] altOeFGHm = altOeFGH | 19'h00700;

   pfc_pad_mux #(.WIDTH(19)) u_mux_fgh (
      .clk(clk),
      .resetn(resetn),
      .altSel(altSelFGH),
      .gpOut(gpOutFGH),
      .gpOe(gpOeFGH),
      .altOut(altOutFGHm),
      .altOe(altOeFGHm),
      .padOut(padOutFGH),
      .padOe(padOeFGH)
   );
endmodule
`default_nettype wire

/* File: verif/pfc_host_model.sv */
`default_nettype none
module pfc_host_model (
   // clock
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic run,
   // host bus
   output logic hostAccess,
   output logic [2:0] hostAddrHi
);
   logic [7:0] rndReg;
   // ------
   // host cycles
   // ------
   // address held in a cycle, wanders between cycles
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rndReg <= 8'hA7;
         hostAccess <= 1'h0;
         hostAddrHi <= 3'h0;
      end else begin
         rndReg <= {rndReg[6:0], ^(rndReg & 8'hB8)};
         hostAccess <= run & rndReg[0];
         if (!hostAccess) hostAddrHi <= rndReg[3:1];
      end
   end
endmodule
`default_nettype wire

/* File: verif/pfc_top_properties.sv */
`default_nettype none
module pfc_top_properties (
   // clock
   input wire logic clk,
   input wire logic resetn,
   // status
   input wire pfc_pkg::pfc_env_e envState,
   input wire logic shadowActive,
   input wire logic externalMemEnable,
   input wire logic externalWide,
   input wire logic hostAccessAllowed,
   input wire logic hostAccess,
   input wire logic [2:0] hostAddrHi,
   input wire logic [2:0] memAddrHi,
   // pads
   input wire logic [31:0] altOutBE,
   input wire logic [31:0] padOutBE,
   input wire logic [31:0] padOeBE,
   input wire logic [18:0] gpOutFGH,
   input wire logic [18:0] altOutFGH,
   input wire logic [18:0] padOutFGH,
   input wire logic [18:0] padOeFGH
);
   import pfc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ------
   // pads lag their inputs by one edge
   // ------
   sequence sRun;
      $past(resetn);
   endsequence
   sequence sRun2;
      $past(resetn) && $past(resetn, 2);
   endsequence
   chk_b5_high: assert property (
      sRun |-> padOutBE[5] && padOeBE[5]) else $error("b5 not high");
   chk_b6_alt: assert property (
      sRun |-> padOeBE[6] && padOutBE[6] == $past(altOutBE[6]))
      else $error("b6 not alternate");
   chk_cfg_cleared: assert property (
      !$past(resetn) |-> shadowActive && !externalMemEnable
      && !externalWide && !hostAccessAllowed) else $error("not cleared");
   chk_shadow_ext: assert property (
      sRun |-> shadowActive != externalMemEnable) else $error("shadow");
   chk_host_addr: assert property (
      hostAccess && hostAccessAllowed && $past(hostAccessAllowed)
      |=> memAddrHi == $past(hostAddrHi)) else $error("host address");
   chk_f_wide: assert property (
      sRun ##0 (envState != PFC_ENV_IRE || externalWide)
      |-> padOutFGH[7:0] == $past(altOutFGH[7:0])
      && padOutFGH[12] == $past(altOutFGH[12])) else $error("wide pins");
   chk_f_narrow: assert property (
      sRun ##0 (envState == PFC_ENV_IRE && !externalWide)
      |-> padOutFGH[7:0] == $past(gpOutFGH[7:0])) else $error("narrow");
   chk_h_env: assert property (
      sRun |-> padOutFGH[18:13] == (envState == PFC_ENV_DEV ?
      $past(altOutFGH[18:13]) : $past(gpOutFGH[18:13]))) else $error("h");
   // divided clock, so it must flip at every edge
   chk_clk_out: assert property (
      sRun2 ##0 (envState != PFC_ENV_IRE && $past(envState) != PFC_ENV_IRE)
      |-> padOeFGH[10] && padOutFGH[10] != $past(padOutFGH[10]))
      else $error("clock pin");
endmodule
bind pfc_top pfc_top_properties pfc_top_properties_i (.*);
`default_nettype wire

/* File: verif/pfc_top_bench.sv */
`default_nettype none
module pfc_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pfc_pkg::*;
   logic clk = '0, resetn = '0, porResetn = '0, wbCyc = '0, wbStb = '0;
   logic wbWe = '0, activeMode = '1, testHook = '1, sharedBiosDetect = '0;
   logic environmentStrapLo = '0, environmentStrapHi = '0, hostRun = '0;
   logic [4:0] wbAdr = '0;
   logic [3:0] wbSel = 4'h1;
   logic [31:0] wbDatI = '0, gpOutBE = '0, altOutBE = '0, gpOeBE = '0;
   logic [31:0] altOeBE = '0, rnd = 32'h14, q, sel = '0;
   logic [18:0] gpOutFGH = '0, altOutFGH = '0, gpOeFGH = '0, altOeFGH = '0;
   logic [7:0] c;
   wire logic [31:0] wbDatO, padOutBE, padOeBE;
   wire logic [18:0] padOutFGH, padOeFGH;
   wire logic [2:0] hostAddrHi, memAddrHi;
   wire logic wbAck, hostAccess, hostAccessAllowed, shadowActive;
   wire logic externalMemEnable, externalWide;
   pfc_env_e envState, env = PFC_ENV_IRE;
   int errTotal = 0, totalChecks = 0, i, e;
   pfc_top pfc_top_i (.*);
   pfc_host_model pfc_host_model_i (.clk, .resetn, .run(hostRun),
      .hostAccess, .hostAddrHi);
   always #2.5 clk = ~clk;
   // ------
   // expectations and bus cycles
   // ------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] expBE(input logic [31:0] s, g, a);
      logic [31:0] m;
      m = (s & ~32'h60) | 32'h40;
      return (a & m) | (g & ~m) | 32'h20;
   endfunction
   // clock pin left out: its phase is not ours to predict
   function automatic logic [18:0] expFGH(input logic [18:0] g, a);
      logic internal_rom_env;
      logic [18:0] m;
      internal_rom_env = env == PFC_ENV_IRE;
      m = {{6{env == PFC_ENV_DEV}}, {2{!internal_rom_env | c[2]}}, 1'h0, !internal_rom_env | c[3],
         !internal_rom_env | c[4], {8{!internal_rom_env | c[2]}}};
      return ((a & m) | (g & ~m)) & ~19'h400;
   endfunction
   task automatic complete_run;
      $display("checks %0d errors %0d", totalChecks, errTotal);
      if (errTotal == 0 && totalChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, x);
      totalChecks++;
      if (g !== x) begin
         errTotal++;
         $display("unexpected at %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= {24'h0, d};
      for (n = 0; n < 20 && wbAck !== 1'h1; n++) @(posedge clk);
      if (n == 20) begin
         errTotal++;
         complete_run();
      end
      q = wbDatO;
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] x);
      wb(1'h0, a, 8'h00);
      cmp(q, {24'h0, x});
   endtask
   task automatic por(input logic lo, hi);
      environmentStrapLo <= lo;
      environmentStrapHi <= hi;
      resetn <= 1'h0;
      porResetn <= 1'h0;
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      porResetn <= 1'h1;
      // straps and test pin settle through the synchroniser first
      repeat (4) @(posedge clk);
   endtask
   task automatic pads;
      rnd = lfsr(rnd);
      gpOutBE <= rnd;
      altOutBE <= ~rnd;
      gpOutFGH <= rnd[18:0];
      altOutFGH <= rnd[31:13];
      gpOeBE <= {rnd[7:0], rnd[31:8]};
      altOeBE <= {rnd[23:0], rnd[31:24]};
      gpOeFGH <= rnd[31:13] ^ rnd[18:0];
      altOeFGH <= rnd[24:6];
      repeat (2) @(posedge clk);
      cmp(padOeBE, expBE(sel, gpOeBE, altOeBE | 32'h40));
      cmp({13'h0, padOeFGH & ~19'h400},
         {13'h0, expFGH(gpOeFGH, altOeFGH | 19'h700)});
      cmp(padOutBE, expBE(sel, gpOutBE, altOutBE));
      cmp({13'h0, padOutFGH & ~19'h400},
         {13'h0, expFGH(gpOutFGH, altOutFGH)});
   endtask
   // ------
   // main sequence
   // ------
   initial begin
      por(1'h0, 1'h0);
      rd(5'h00, 8'h40);
      activeMode <= 1'h0;
      repeat (4) @(posedge clk);
      wb(1'h1, 5'h00, 8'h2C);
      rd(5'h00, 8'h40);
      activeMode <= 1'h1;
      testHook <= 1'h0;
      repeat (4) @(posedge clk);
      wb(1'h1, 5'h00, 8'hE4);
      rd(5'h00, 8'h24);
      sharedBiosDetect <= 1'h1;
      rd(5'h00, 8'h2C);
      for (i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         c = rnd[7:0] & 8'h3C;
         wb(1'h1, 5'h00, c);
         sel[i % 4 * 8 +: 8] = rnd[15:8];
         wb(1'h1, 5'h08 + 5'(i % 4 * 4), rnd[15:8]);
         rd(5'h08 + 5'(i % 4 * 4), rnd[15:8]);
         pads();
         cmp({31'h0, externalWide}, {31'h0, c[2]});
      end
      wb(1'h1, 5'h04, 8'hFD);
      rd(5'h04, 8'h05);
      c[0] = 1'h1;
      wb(1'h1, 5'h00, c);
      hostRun <= 1'h1;
      // shared enable still clear, so host requests must not steer
      repeat (20) begin
         @(posedge clk);
         cmp({29'h0, memAddrHi}, 32'h5);
      end
      cmp({30'h0, hostAccessAllowed, externalMemEnable}, 32'h1);
      c[1] = 1'h1;
      wb(1'h1, 5'h00, c);
      repeat (40) @(posedge clk);
      cmp({30'h0, hostAccessAllowed, shadowActive}, 32'h2);
      rd(5'h1C, 8'h00);
      rd(5'h18, 8'h01);
      for (e = 1; e < 3; e++) begin
         por(e[1], e[0]);
         env = pfc_env_e'(3'h1 << e);
         c = 8'h00;
         sel = '0;
         rd(5'h18, 8'h01 << e);
         cmp({29'h0, envState}, {29'h0, env});
         // detect input still high, so address15 enable comes back
         rd(5'h00, 8'h08);
         pads();
      end
      complete_run();
   end
   initial begin
      repeat (100000) @(posedge clk);
      errTotal++;
      complete_run();
   end
endmodule
`default_nettype wire
